// File: bench/tb_usb_uart_config_loader.sv
`timescale 1ns/1ps
`default_nettype none
module tb_usb_uart_config_loader
  import ucl_pkg::*;
;
  // Identifier defaults, values are arbitrary
  localparam logic [15:0] VID_T = 16'h1357;
  localparam logic [15:0] PID_T = 16'h2468;
  localparam logic [31:0] SER_T = 32'h0000_0ABC;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, desc_serial;
  logic usb_bus_reset, usb_configured, usb_suspend, ext_osc_present;
  logic tx_activity, rx_activity, tx_frame_active, core_txd, core_rts_n;
  logic core_dtr_n, core_rxd, core_cts_n, core_dsr_n, core_carrier_detect_n;
  logic core_ring_indicator_n, uart_txd, uart_rts_n, uart_dtr_n, uart_rxd;
  logic uart_cts_n, uart_dsr_n, carrier_detect_n, ring_indicator_n;
  logic uart_pulldown_en, osc_select_ext, device_halt, device_ready;
  logic remote_wake_req, driver_bind, desc_serial_valid;
  logic [4:0] config_pin_o, config_pin_oe;
  logic [15:0] desc_vendor_identifier, desc_product_identifier;
  logic [15:0] desc_usb_version;
  logic [7:0] desc_max_power, desc_attributes;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int wake_cnt = 0;
  logic [31:0] q;
  logic e;

  // Short wake and LED counts keep the run brief
  ucl_config_loader #(
    .VENDOR_ID_DFLT(VID_T),
    .PRODUCT_ID_DFLT(PID_T),
    .SERIAL_DFLT(SER_T),
    .WAKE_CYCLES_P(20),
    .LED_CYCLES_P(4)
  ) ucl_config_loader_i (.*);
  ucl_usb_host_model ucl_usb_host_model_i (.*);

  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard and wake pulse counter
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (remote_wake_req === 1'b1)
      wake_cnt <= wake_cnt + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never reassigns psel in this step
    @(posedge pclk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), q, exp);
  endtask

  // Poll the status word until the load reports done
  task wait_done;
    int n;
    n = 0;
    q = 32'h0;
    while (q[0] !== 1'b1 && n < 20)
    begin
      apb(1'b0, A_STATUS, 32'h0);
      n++;
    end
    chk("load_done", q & 32'h1, 32'h1);
  endtask

  task tally_and_finish;
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
    {ext_osc_present, tx_activity, rx_activity, tx_frame_active} <= '0;
    {core_txd, core_rts_n, core_dtr_n, uart_rxd, uart_cts_n} <= 5'h1F;
    {uart_dsr_n, carrier_detect_n, ring_indicator_n} <= 3'h7;
    repeat (10) @(posedge pclk);
    chk("oe_in_reset", 32'(config_pin_oe), 32'h0);
    presetn <= 1'b1;
    wait_done;
    rd(A_ACT_IDS, {PID_T, VID_T});
    rd(A_ACT_FLAGS, FLAGS_RST);
    rd(A_ACT_CBUS, CBUS_RST);
    rd(A_ACT_INV, INV_RST);
    rd(A_SERIAL, SER_T);
    rd(A_DESC, {ATTR_BASE | ATTR_WAKE, MAXPWR_90MA, USB_VERSION});
    chk("usb_version", 32'(desc_usb_version), 32'h200);
    chk("osc_ext", 32'(osc_select_ext), 32'h0);
    chk("driver_bind", 32'(driver_bind), 32'h1);
    chk("ready", 32'(device_ready), 32'h1);
    chk("desc_vid", 32'(desc_vendor_identifier), 32'(VID_T));
    chk("desc_pid", 32'(desc_product_identifier), 32'(PID_T));
    chk("desc_attr", 32'(desc_attributes), 32'(ATTR_BASE | ATTR_WAKE));
    chk("desc_maxpwr", 32'(desc_max_power), 32'(MAXPWR_90MA));
    chk("serial_valid_on", 32'(desc_serial_valid), 32'h1);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped_err", 32'(e), 32'h1);
    chk("unmapped_data", q, 32'h0);
    // Lines pass straight through while no invert flag is set
    {core_rts_n, core_dtr_n, uart_cts_n, uart_dsr_n, carrier_detect_n} <=
      5'h00;
    repeat (4) @(posedge pclk);
    chk("rts_dtr", 32'({uart_rts_n, uart_dtr_n}), 32'h0);
    chk("cts_dsr", 32'({core_cts_n, core_dsr_n}), 32'h0);
    chk("dcd_through", 32'(core_carrier_detect_n), 32'h0);
    {core_rts_n, core_dtr_n, uart_cts_n, uart_dsr_n, carrier_detect_n} <=
      5'h1F;
    // Activity pins drive low only while stretched activity lasts
    for (int i = 0; i < 2; i++)
    begin
      tx_activity <= (i == 0);
      rx_activity <= (i == 1);
      repeat (3) @(posedge pclk);
      chk("led_oe", 32'(config_pin_oe[i]), 32'h1);
      chk("led_level", 32'(config_pin_o[i]), 32'h0);
      {tx_activity, rx_activity} <= 2'h0;
      repeat (12) @(posedge pclk);
      chk("led_off", 32'(config_pin_oe[i]), 32'h0);
    end
    tx_frame_active <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("rs485_en", 32'(config_pin_o[2] & config_pin_oe[2]), 32'h1);
    tx_frame_active <= 1'b0;
    chk("pwr_unconf", 32'(config_pin_o[3]), 32'h1);
    ucl_usb_host_model_i.enumerate();
    repeat (5) @(posedge pclk);
    chk("pwr_conf", 32'(config_pin_o[3]), 32'h0);
    chk("sleep_awake", 32'(config_pin_o[4]), 32'h1);
    ucl_usb_host_model_i.suspend_bus(1'b1);
    repeat (5) @(posedge pclk);
    chk("pwr_susp", 32'(config_pin_o[3]), 32'h1);
    chk("sleep_susp", 32'(config_pin_o[4]), 32'h0);
    chk("pulldown_off", 32'(uart_pulldown_en), 32'h0);
    // Ring held low during suspend gives exactly one wake pulse
    ring_indicator_n <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("wake_once", 32'(wake_cnt), 32'h1);
    repeat (40) @(posedge pclk);
    chk("wake_held", 32'(wake_cnt), 32'h1);
    ring_indicator_n <= 1'b1;
    ucl_usb_host_model_i.suspend_bus(1'b0);
    // Host rewrites the store; active values wait for the next load
    apb(1'b1, A_ST_INDEX, 32'h0);
    apb(1'b1, A_ST_DATA, 32'hBEEF_C0DE);
    apb(1'b1, A_ST_INDEX, 32'h1);
    apb(1'b1, A_ST_DATA, 32'h0000_323E);
    rd(A_ST_DATA, 32'h0000_323E);
    apb(1'b1, A_ST_INDEX, 32'h3);
    apb(1'b1, A_ST_DATA, 32'h0000_00FF);
    rd(A_ACT_FLAGS, FLAGS_RST);
    apb(1'b1, A_CTRL, 32'h1);
    wait_done;
    rd(A_ACT_IDS, 32'hBEEF_C0DE);
    chk("desc_vid_new", 32'(desc_vendor_identifier), 32'h0000_C0DE);
    rd(A_DESC, {8'hE0, 8'h32, USB_VERSION});
    rd(A_SERIAL, 32'h0);
    chk("serial_valid", 32'(desc_serial_valid), 32'h0);
    chk("osc_ext_set", 32'(osc_select_ext), 32'h1);
    chk("halt", 32'(device_halt), 32'h1);
    chk("not_ready", 32'(device_ready), 32'h0);
    repeat (4) @(posedge pclk);
    chk("txd_inv", 32'(uart_txd), 32'h0);
    chk("rxd_inv", 32'(core_rxd), 32'h0);
    chk("ri_inv", 32'(core_ring_indicator_n), 32'h0);
    ucl_usb_host_model_i.suspend_bus(1'b1);
    repeat (5) @(posedge pclk);
    chk("pulldown_on", 32'(uart_pulldown_en), 32'h1);
    ucl_usb_host_model_i.suspend_bus(1'b0);
    // Bus reset reloads the active copy from the store with the oscillator now fitted
    ext_osc_present <= 1'b1;
    ucl_usb_host_model_i.bus_reset();
    repeat (4) @(posedge pclk);
    wait_done;
    chk("halt_clear", 32'(device_halt), 32'h0);
    chk("ready_again", 32'(device_ready), 32'h1);
    rd(A_ACT_INV, 32'h0000_00FF);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// File: bench/ucl_usb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side USB host: enumerates, suspends and resets the bus
module ucl_usb_host_model (
  input wire logic pclk,
  output logic usb_bus_reset,
  output logic usb_configured,
  output logic usb_suspend
);
  // Bus starts idle and unconfigured
  initial
  begin
    usb_bus_reset <= 1'b0;
    usb_configured <= 1'b0;
    usb_suspend <= 1'b0;
  end

  task enumerate;
    @(posedge pclk);
    usb_configured <= 1'b1;
  endtask

  task suspend_bus(input logic on);
    @(posedge pclk);
    usb_suspend <= on;
  endtask

  // A bus reset drops configuration, so the device must enumerate again
  task bus_reset;
    @(posedge pclk);
    usb_bus_reset <= 1'b1;
    usb_configured <= 1'b0;
    repeat (3) @(posedge pclk);
    usb_bus_reset <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: rtl/ucl_config_loader.sv
`timescale 1ns/1ps
`default_nettype none
module ucl_config_loader #(
  parameter logic [15:0] VENDOR_ID_DFLT = 16'hA5A5, // Arbitrary value
  parameter logic [15:0] PRODUCT_ID_DFLT = 16'h5A01, // Arbitrary value
  parameter logic [31:0] SERIAL_DFLT = 32'h0000_1234, // Arbitrary value
  parameter int WAKE_CYCLES_P = ucl_pkg::WAKE_CYCLES,
  parameter int LED_CYCLES_P = ucl_pkg::LED_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ucl_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_bus_reset,
  input wire logic usb_configured,
  input wire logic usb_suspend,
  input wire logic ext_osc_present,
  input wire logic tx_activity,
  input wire logic rx_activity,
  input wire logic tx_frame_active,
  input wire logic core_txd,
  input wire logic core_rts_n,
  input wire logic core_dtr_n,
  output logic core_rxd,
  output logic core_cts_n,
  output logic core_dsr_n,
  output logic core_carrier_detect_n,
  output logic core_ring_indicator_n,
  output logic uart_txd,
  output logic uart_rts_n,
  output logic uart_dtr_n,
  input wire logic uart_rxd,
  input wire logic uart_cts_n,
  input wire logic uart_dsr_n,
  input wire logic carrier_detect_n,
  input wire logic ring_indicator_n,
  output logic uart_pulldown_en,
  output logic [4:0] config_pin_o,
  output logic [4:0] config_pin_oe,
  output logic osc_select_ext,
  output logic device_halt,
  output logic device_ready,
  output logic remote_wake_req,
  output logic driver_bind,
  output logic [15:0] desc_vendor_identifier,
  output logic [15:0] desc_product_identifier,
  output logic [15:0] desc_usb_version,
  output logic [7:0] desc_max_power,
  output logic [7:0] desc_attributes,
  output logic desc_serial_valid,
  output logic [31:0] desc_serial
);
  import ucl_pkg::*;

  localparam int WCW = $clog2(WAKE_CYCLES_P + 1);
  localparam int LCW = $clog2(LED_CYCLES_P + 1);
  localparam logic [WCW-1:0] WAKE_LAST = WCW'(WAKE_CYCLES_P - 1);
  localparam logic [LCW-1:0] LED_LAST = LCW'(LED_CYCLES_P - 1);

  // Pin inputs pass two flops; index order matches sync_s users below
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  wire logic [8:0] sync_raw;
  assign sync_raw = {ring_indicator_n, carrier_detect_n, uart_dsr_n,
    uart_cts_n, uart_rxd, ext_osc_present, usb_suspend, usb_configured,
    usb_bus_reset};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 9'h1F0; // UART lines idle high: no false start bit
      sync2_reg <= 9'h1F0;
    end
    else
    begin
      sync1_reg <= sync_raw;
      sync2_reg <= sync1_reg;
    end
  end

  wire logic bus_reset_s;
  wire logic configured_s;
  wire logic suspend_s;
  wire logic ext_present_s;
  wire logic [4:0] line_in_s;
  assign bus_reset_s = sync2_reg[0];
  assign configured_s = sync2_reg[1];
  assign suspend_s = sync2_reg[2];
  assign ext_present_s = sync2_reg[3];
  assign line_in_s = sync2_reg[8:4];

  // Edge detect on the synchronised bus reset
  logic bus_reset_d_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_reset_d_reg <= 1'b0;
    else
      bus_reset_d_reg <= bus_reset_s;
  end

  // APB decode; the slave never inserts wait states
  wire logic acc;
  wire logic wr_en;
  wire logic mapped;
  wire logic st_idx_ok;
  wire logic reload_req;
  wire logic trigger;
  assign acc = psel && penable;
  assign wr_en = acc && pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= A_DESC);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign reload_req = wr_en && (paddr == A_CTRL) && pwdata[0];
  assign trigger = (bus_reset_s && !bus_reset_d_reg) || reload_req;

  // Nonvolatile store image; survives bus resets, only power-on restores it
  logic [31:0] store_reg [STORE_WORDS];
  logic [2:0] st_index_reg;
  assign st_idx_ok = st_index_reg <= LAST_IDX;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_index_reg <= 3'h0;
    else if (wr_en && paddr == A_ST_INDEX)
      st_index_reg <= pwdata[2:0];
  end

  // Host rewrites words here; effect waits for the next load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      store_reg[W_IDS] <= {PRODUCT_ID_DFLT, VENDOR_ID_DFLT};
      store_reg[W_FLAGS] <= FLAGS_RST;
      store_reg[W_CBUS] <= CBUS_RST;
      store_reg[W_INV] <= INV_RST;
      store_reg[W_SERIAL] <= SERIAL_DFLT;
    end
    else if (wr_en && paddr == A_ST_DATA && st_idx_ok)
      store_reg[st_index_reg] <= pwdata;
  end

  // Loader: copies one word per cycle, restarts on every trigger
  ucl_load_e ld_state_reg;
  logic [2:0] ld_idx_reg;
  wire logic load_done;
  assign load_done = ld_state_reg == LD_DONE;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ld_state_reg <= LD_LOAD;
      ld_idx_reg <= 3'h0;
    end
    else if (trigger)
    begin
      ld_state_reg <= LD_LOAD;
      ld_idx_reg <= 3'h0;
    end
    else
    begin
      case (ld_state_reg)
        LD_LOAD:
        begin
          if (ld_idx_reg == LAST_IDX)
            ld_state_reg <= LD_DONE;
          else
            ld_idx_reg <= ld_idx_reg + 3'h1;
        end
        LD_DONE: ld_state_reg <= LD_DONE;
        default: ld_state_reg <= LD_LOAD;
      endcase
    end
  end

  // Active copy; cleared by reset so nothing takes effect before a load
  logic [31:0] act_reg [STORE_WORDS];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < STORE_WORDS; i++)
        act_reg[i] <= 32'h0000_0000;
    end
    else if (ld_state_reg == LD_LOAD)
      act_reg[ld_idx_reg] <= store_reg[ld_idx_reg];
  end

  // Loaded option fields
  wire logic serial_en;
  wire logic pulldn_en;
  wire logic wake_en;
  wire logic ext_osc_sel;
  wire logic self_pwr;
  wire logic [7:0] inv_eff;
  assign serial_en = act_reg[W_FLAGS][FB_SERIAL];
  assign pulldn_en = act_reg[W_FLAGS][FB_PULLDN];
  assign wake_en = act_reg[W_FLAGS][FB_WAKE];
  assign ext_osc_sel = act_reg[W_FLAGS][FB_EXTOSC];
  assign self_pwr = act_reg[W_FLAGS][FB_SELFPWR];
  assign inv_eff = load_done ? act_reg[W_INV][7:0] : 8'h00;

  // Descriptor fields from the active copy; the USB version is the fixed USB_VERSION
  assign desc_vendor_identifier = act_reg[W_IDS][15:0];
  assign desc_product_identifier = act_reg[W_IDS][31:16];
  assign desc_usb_version = USB_VERSION;
  assign desc_max_power = act_reg[W_FLAGS][FB_MAXPWR+:8];
  assign desc_attributes = ATTR_BASE | (self_pwr ? ATTR_SELF : 8'h00) |
    (wake_en ? ATTR_WAKE : 8'h00);
  assign desc_serial_valid = serial_en && load_done;
  assign desc_serial = serial_en ? act_reg[W_SERIAL] : 32'h0000_0000;
  assign driver_bind = act_reg[W_FLAGS][FB_DRIVER];

  // Line inversion; both directions registered so pins see clean edges
  wire logic [2:0] out_inv;
  wire logic [4:0] in_inv;
  assign out_inv = {inv_eff[IV_DTR], inv_eff[IV_RTS], inv_eff[IV_TXD]};
  assign in_inv = {inv_eff[IV_RI], inv_eff[IV_DCD], inv_eff[IV_DSR],
    inv_eff[IV_CTS], inv_eff[IV_RXD]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {uart_dtr_n, uart_rts_n, uart_txd} <= 3'h7;
      {core_ring_indicator_n, core_carrier_detect_n, core_dsr_n,
        core_cts_n, core_rxd} <= 5'h1F;
    end
    else
    begin
      {uart_dtr_n, uart_rts_n, uart_txd} <=
        {core_dtr_n, core_rts_n, core_txd} ^ out_inv;
      {core_ring_indicator_n, core_carrier_detect_n, core_dsr_n,
        core_cts_n, core_rxd} <= line_in_s ^ in_inv;
    end
  end

  // Power, sleep, pull-down and oscillator state
  logic power_enable_n_reg;
  logic sleep_n_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_enable_n_reg <= 1'b1;
      sleep_n_reg <= 1'b1;
      uart_pulldown_en <= 1'b0;
      osc_select_ext <= 1'b0;
      device_halt <= 1'b0;
      device_ready <= 1'b0;
    end
    else
    begin
      power_enable_n_reg <= !(load_done && configured_s && !suspend_s);
      sleep_n_reg <= !suspend_s;
      uart_pulldown_en <= load_done && pulldn_en && suspend_s;
      osc_select_ext <= load_done && ext_osc_sel;
      device_halt <= load_done && ext_osc_sel && !ext_present_s;
      device_ready <= load_done && !(ext_osc_sel && !ext_present_s);
    end
  end

  // Ring held low while suspended wakes the host once; count stops at 20 ms
  logic [WCW-1:0] wake_cnt_reg;
  wire logic ring_low;
  assign ring_low = !core_ring_indicator_n && suspend_s && wake_en &&
    load_done;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_cnt_reg <= '0;
      remote_wake_req <= 1'b0;
    end
    else
    begin
      remote_wake_req <= ring_low && (wake_cnt_reg == WAKE_LAST);
      if (!ring_low)
        wake_cnt_reg <= '0;
      else if (wake_cnt_reg <= WAKE_LAST)
        wake_cnt_reg <= wake_cnt_reg + WCW'(1);
    end
  end

  // One-shot stretch so short bursts stay visible on an LED
  logic [LCW-1:0] tx_led_cnt_reg;
  logic [LCW-1:0] rx_led_cnt_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_led_cnt_reg <= '0;
      rx_led_cnt_reg <= '0;
    end
    else
    begin
      tx_led_cnt_reg <= tx_activity ? LED_LAST :
        (tx_led_cnt_reg != '0) ? tx_led_cnt_reg - LCW'(1) : '0;
      rx_led_cnt_reg <= rx_activity ? LED_LAST :
        (rx_led_cnt_reg != '0) ? rx_led_cnt_reg - LCW'(1) : '0;
    end
  end

  // Function sources and per-pin selection
  ucl_pin_if pif ();
  assign pif.tx_led_n = !(tx_activity || tx_led_cnt_reg != '0);
  assign pif.rx_led_n = !(rx_activity || rx_led_cnt_reg != '0);
  assign pif.txrx_led_n = pif.tx_led_n && pif.rx_led_n;
  assign pif.rs485_drive_enable = tx_frame_active;
  assign pif.power_enable_n = power_enable_n_reg;
  assign pif.sleep_n = sleep_n_reg;

  wire logic [4:0] pin_o_w;
  wire logic [4:0] pin_oe_w;
  for (genvar g = 0; g < 5; g++)
  begin : g_pin
    ucl_pin_mux u_mux (
      .srcs(pif),
      .func(act_reg[W_CBUS][4*g+:4]),
      .enable(load_done),
      .pin_o(pin_o_w[g]),
      .pin_oe(pin_oe_w[g])
    );
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      config_pin_o <= 5'h00;
      config_pin_oe <= 5'h00;
    end
    else
    begin
      config_pin_o <= pin_o_w;
      config_pin_oe <= pin_oe_w;
    end
  end

  // Read mux; sampled in the setup phase, stable through access
  wire logic [31:0] status_w;
  wire logic [31:0] rd_data;
  assign status_w = {27'h0, configured_s, suspend_s, device_halt,
    !load_done, load_done};
  assign rd_data =
    (paddr == A_STATUS) ? status_w :
    (paddr == A_ST_INDEX) ? {29'h0, st_index_reg} :
    (paddr == A_ST_DATA) ? (st_idx_ok ? store_reg[st_index_reg] : 32'h0) :
    (paddr == A_ACT_IDS) ? act_reg[W_IDS] :
    (paddr == A_ACT_FLAGS) ? act_reg[W_FLAGS] :
    (paddr == A_ACT_CBUS) ? act_reg[W_CBUS] :
    (paddr == A_ACT_INV) ? act_reg[W_INV] :
    (paddr == A_SERIAL) ? desc_serial :
    (paddr == A_DESC) ? {desc_attributes, desc_max_power, USB_VERSION} :
    32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= rd_data;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bus_reset_reload: assert property (
    bus_reset_s && !bus_reset_d_reg |=> !load_done [*5] ##1 load_done
      || $past(reload_req) || trigger)
    else $error("bus reset did not reload the store");
  a_load_last_word: assert property (
    $rose(load_done) |-> $past(ld_idx_reg) == LAST_IDX)
    else $error("load ended before the last word");
  a_version_read: assert property (
    psel && !penable && paddr == A_DESC |=> prdata[15:0] == 16'h0200)
    else $error("descriptor version is not 0200");
  a_serial_gated: assert property (
    psel && !penable && paddr == A_SERIAL && !serial_en
      |=> prdata == 32'h0)
    else $error("serial readable while disabled");
  a_pulldown_susp: assert property (
    uart_pulldown_en |-> $past(suspend_s) && $past(pulldn_en))
    else $error("pull-down outside suspend");
  a_power_enable: assert property (
    load_done && configured_s && !suspend_s ##1 load_done
      |-> !power_enable_n_reg)
    else $error("power enable not low after enumeration");
  a_power_suspend: assert property (
    suspend_s |=> power_enable_n_reg)
    else $error("power enable low in suspend");
  a_sleep_level: assert property (
    $changed(suspend_s) |=> sleep_n_reg == !$past(suspend_s))
    else $error("sleep output does not follow suspend");
  a_wake_bound: assert property (
    remote_wake_req |-> $past(ring_low) && $past(wake_cnt_reg) == WAKE_LAST)
    else $error("wake request at wrong count");
  a_txd_invert: assert property (
    load_done ##1 load_done
      |-> uart_txd == ($past(core_txd) ^ $past(inv_eff[IV_TXD])))
    else $error("transmit line inversion wrong");
  a_osc_halt: assert property (
    device_halt |-> !device_ready)
    else $error("ready while oscillator missing");
  a_safe_pins: assert property (
    !load_done ##1 !load_done |-> config_pin_oe == 5'h00)
    else $error("pin driven before load completed");

endmodule
`default_nettype wire

// File: rtl/ucl_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
// Function sources shared by every configurable pin
interface ucl_pin_if;
  logic tx_led_n;
  logic rx_led_n;
  logic txrx_led_n;
  logic rs485_drive_enable;
  logic power_enable_n;
  logic sleep_n;
  modport src (
    output tx_led_n,
    output rx_led_n,
    output txrx_led_n,
    output rs485_drive_enable,
    output power_enable_n,
    output sleep_n
  );
  modport sink (
    input tx_led_n,
    input rx_led_n,
    input txrx_led_n,
    input rs485_drive_enable,
    input power_enable_n,
    input sleep_n
  );
endinterface
`default_nettype wire

// File: rtl/ucl_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module ucl_pin_mux (
  ucl_pin_if.sink srcs,
  input wire logic [3:0] func,
  input wire logic enable,
  output logic pin_o,
  output logic pin_oe
);
  import ucl_pkg::*;

  // LED drives only sink current; they release the pin when idle
  wire logic is_led;
  wire logic led_n;
  wire logic push_val;
  wire logic push_ok;

  assign is_led = (func == FN_TX_ACTIVITY_LED_N) || (func == FN_RX_ACTIVITY_LED_N) ||
    (func == FN_TXRXLED);
  assign led_n = (func == FN_TX_ACTIVITY_LED_N) ? srcs.tx_led_n :
    (func == FN_RX_ACTIVITY_LED_N) ? srcs.rx_led_n : srcs.txrx_led_n;
  assign push_ok = (func == FN_RS485_DRIVE_ENABLE) || (func == FN_POWER_ENABLE_N) ||
    (func == FN_SLEEP);
  assign push_val = (func == FN_RS485_DRIVE_ENABLE) ? srcs.rs485_drive_enable :
    (func == FN_POWER_ENABLE_N) ? srcs.power_enable_n : srcs.sleep_n;

  // Unknown codes and the pre-load phase leave the pin undriven
  assign pin_o = is_led ? 1'b0 : push_val;
  assign pin_oe = enable && ((is_led && !led_n) || push_ok);

endmodule
`default_nettype wire

// File: rtl/ucl_pkg.sv
`default_nettype none
package ucl_pkg;

  // Store layout, one 32-bit word per index
  localparam int STORE_WORDS = 5;
  localparam logic [2:0] W_IDS = 3'h0;
  localparam logic [2:0] W_FLAGS = 3'h1;
  localparam logic [2:0] W_CBUS = 3'h2;
  localparam logic [2:0] W_INV = 3'h3;
  localparam logic [2:0] W_SERIAL = 3'h4;
  localparam logic [2:0] LAST_IDX = 3'h4;

  // Option flag positions inside the flags word
  localparam int FB_SERIAL = 0;
  localparam int FB_PULLDN = 1;
  localparam int FB_WAKE = 2;
  localparam int FB_DRIVER = 3;
  localparam int FB_EXTOSC = 4;
  localparam int FB_SELFPWR = 5;
  localparam int FB_MAXPWR = 8;

  // Max power is kept in 2 mA units, as the descriptor carries it
  localparam logic [7:0] MAXPWR_90MA = 8'h2D;
  localparam logic [31:0] FLAGS_RST = {16'h0000, MAXPWR_90MA, 8'h0D};

  // Configurable pin function codes, four bits per pin
  localparam logic [3:0] FN_TX_ACTIVITY_LED_N = 4'h0;
  localparam logic [3:0] FN_RX_ACTIVITY_LED_N = 4'h1;
  localparam logic [3:0] FN_RS485_DRIVE_ENABLE = 4'h2;
  localparam logic [3:0] FN_POWER_ENABLE_N = 4'h3;
  localparam logic [3:0] FN_SLEEP = 4'h4;
  localparam logic [3:0] FN_TXRXLED = 4'h5;
  localparam logic [31:0] CBUS_RST =
    {12'h000, FN_SLEEP, FN_POWER_ENABLE_N, FN_RS485_DRIVE_ENABLE, FN_RX_ACTIVITY_LED_N, FN_TX_ACTIVITY_LED_N};

  // Invert flag positions
  localparam int IV_TXD = 0;
  localparam int IV_RXD = 1;
  localparam int IV_RTS = 2;
  localparam int IV_CTS = 3;
  localparam int IV_DTR = 4;
  localparam int IV_DSR = 5;
  localparam int IV_DCD = 6;
  localparam int IV_RI = 7;
  localparam logic [31:0] INV_RST = 32'h0000_0000;

  // Descriptor constants
  localparam logic [15:0] USB_VERSION = 16'h0200;
  localparam logic [7:0] ATTR_BASE = 8'h80;
  localparam logic [7:0] ATTR_SELF = 8'h40;
  localparam logic [7:0] ATTR_WAKE = 8'h20;

  // APB byte addresses
  localparam int AW = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_ST_INDEX = 8'h08;
  localparam logic [7:0] A_ST_DATA = 8'h0C;
  localparam logic [7:0] A_ACT_IDS = 8'h10;
  localparam logic [7:0] A_ACT_FLAGS = 8'h14;
  localparam logic [7:0] A_ACT_CBUS = 8'h18;
  localparam logic [7:0] A_ACT_INV = 8'h1C;
  localparam logic [7:0] A_SERIAL = 8'h20;
  localparam logic [7:0] A_DESC = 8'h24;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int WAKE_TIME_MS = 20;
  localparam int WAKE_CYCLES = WAKE_TIME_MS * 1000 * CLK_MHZ;
  localparam int LED_TIME_US = 50;
  localparam int LED_CYCLES = LED_TIME_US * CLK_MHZ;

  typedef enum logic {LD_LOAD, LD_DONE} ucl_load_e;

endpackage
`default_nettype wire
